// ==== hw/sdm_bank_ctrl.v ====
// Summary of operation
// [R1] Controller sends only inhibit/nop in global periods
// [R2] Refresh lasts refresh_cycle_time, then all idle
// [R3] Mode load lasts mode_set_delay, then all idle
// [R4] Precharge-all lasts precharge_time, then all idle
// [R5] Auto-precharge bank idles after precharge_time
// [R6] Refresh and mode load only when all idle
// [R7] Precharge-all needs every bank precharge-valid; the code enters precharge-all on any precharge with a10 high, without checking
// [R8] Burst terminate stops most recent burst
// [R9] Burst terminate never aimed at other bank
// [R10] Unlisted state/command pairs are undefined
// [R11] Precharge to idle bank is a no-op
// [R12] Commands act only with clock enable high twice
// [R13] Idle bank never restricts other banks
// [R14] Precharge elsewhere leaves current burst running
// [R15] Interrupted auto-precharge bank starts precharging
// [R16] Read interrupts read after read_latency
// [R17] Write interrupts read at once; mask before
// [R18] Read interrupts write at once; data later
// [R19] Write interrupts write; earlier data kept
// [R20] Read cuts read-ap; precharge starts then
// [R21] Write cuts read-ap; precharge starts then
// [R22] Read cuts write-ap; recovery then precharge
// [R23] Write cuts write-ap; recovery then precharge
// [R24] Busy bank gets only nop from controller
// [R25] Controller tracks bank and global state
`timescale 1ns/100ps
`default_nettype none
`include "sdm_map.vh"

// ----------------------------------------
// Write data FIFO
// ----------------------------------------
module sdm_fifo #(
  parameter WIDTH = 38,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire sys_clk,
  input wire rst_b,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  wire push;
  wire pop;

  // Honest full and empty from the fill count
  assign in_ready = (cnt_r != DEPTH);
  assign out_valid = (cnt_r != 0);
  assign out_data = mem_r[rp_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointer and count update
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wp_r <= (wp_r == DEPTH - 1) ? {AW{1'b0}} : wp_r + 1'b1;
      if (pop)
        rp_r <= (rp_r == DEPTH - 1) ? {AW{1'b0}} : rp_r + 1'b1;
      if (push & ~pop)
        cnt_r <= cnt_r + 1'b1;
      else if (pop & ~push)
        cnt_r <= cnt_r - 1'b1;
    end
  end

  // Storage, no reset needed
  always @(posedge sys_clk) begin
    if (push)
      mem_r[wp_r] <= in_data;
  end
endmodule // sdm_fifo

// ----------------------------------------
// Bank and global state tracker
// ----------------------------------------
module sdm_bank_ctrl #(
  parameter NBANK = 4,
  parameter READ_LATENCY = 2,
  parameter BURST_LEN = 4,
  parameter FIFO_DEPTH = 8,
  parameter [7:0] PRECHARGE_CYC = `SDM_TRP_CYC,
  parameter [7:0] ACT_CYC = `SDM_ACTIVATE_TO_ACCESS_DELAY_CYC,
  parameter [7:0] REFRESH_CYC = `SDM_REFRESH_CYCLE_TIME_CYC,
  parameter [7:0] MODE_CYC = `SDM_MODE_SET_DELAY_CYC,
  parameter [7:0] WREC_CYC = `SDM_TWR_CYC,
  parameter [7:0] SR_EXIT_CYC = `SDM_SELF_REFRESH_EXIT_DELAY_CYC
) (
  input wire sys_clk,
  input wire rst_b,
  input wire cke,
  input wire cs_b,
  input wire ras_b,
  input wire cas_b,
  input wire we_b,
  input wire [1:0] bank_addr,
  input wire a10,
  input wire [3:0] byte_mask,
  input wire [31:0] dq_in,
  output reg [31:0] dq_out,
  output reg [3:0] dq_oe,
  output wire mem_rd_en,
  output wire [1:0] mem_rd_bank,
  input wire [31:0] mem_rd_data,
  output wire st_valid,
  input wire st_ready,
  output wire [37:0] st_data,
  output wire wr_fifo_ready,
  output wire [4*NBANK-1:0] bank_state,
  output wire [1:0] glob_state,
  output wire all_idle
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg [43:0] pin_s1_r;
  reg [43:0] pin_s2_r;
  wire [3:0] cmd;
  wire [1:0] cba;
  wire ca10;
  wire [3:0] cdqm;
  wire [31:0] cdq;
  wire ccke;

  // Two flops before any use
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      pin_s1_r <= {4'hF, 40'h0};
      pin_s2_r <= {4'hF, 40'h0};
    end else begin
      pin_s1_r <= {cs_b, ras_b, cas_b, we_b, cke, bank_addr, a10,
                   byte_mask, dq_in};
      pin_s2_r <= pin_s1_r;
    end
  end
  assign cmd = pin_s2_r[43:40];
  assign ccke = pin_s2_r[39];
  assign cba = pin_s2_r[38:37];
  assign ca10 = pin_s2_r[36];
  assign cdqm = pin_s2_r[35:32];
  assign cdq = pin_s2_r[31:0];

  // ----------------------------------------
  // Clock-enable qualification
  // ----------------------------------------
  reg cke_prev_r;
  reg [7:0] xsr_cnt_r;
  wire cmd_ok;

  // Hold off commands after clock enable returns
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      cke_prev_r <= 1'b0;
      xsr_cnt_r <= 8'h00;
    end else begin
      cke_prev_r <= ccke;
      if (ccke & ~cke_prev_r)
        xsr_cnt_r <= SR_EXIT_CYC; // see [R12]
      else if (xsr_cnt_r != 8'h00)
        xsr_cnt_r <= xsr_cnt_r - 8'h01;
    end
  end
  assign cmd_ok = ccke & cke_prev_r & (xsr_cnt_r == 8'h00); // see [R12]

  // ----------------------------------------
  // Global state
  // ----------------------------------------
  reg [1:0] gst_r;
  reg [7:0] gcnt_r;
  wire run;
  wire is_act;
  wire is_rd;
  wire is_wr;
  wire is_pre;
  wire is_bst;
  wire is_rw;
  wire g_done;
  wire [NBANK-1:0] bk_idle;

  assign run = cmd_ok & (gst_r == `SDM_GL_RUN) & ~cmd[3];
  assign is_act = run & (cmd == `SDM_CMD_ACT);
  assign is_rd = run & (cmd == `SDM_CMD_RD);
  assign is_wr = run & (cmd == `SDM_CMD_WR);
  assign is_pre = run & (cmd == `SDM_CMD_PRE);
  assign is_bst = run & (cmd == `SDM_CMD_BST);
  assign is_rw = is_rd | is_wr;
  assign g_done = (gst_r != `SDM_GL_RUN) & (gcnt_r == 8'h01);
  assign all_idle = &bk_idle;
  assign glob_state = gst_r;

  // Refresh, mode load and precharge-all periods
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      gst_r <= `SDM_GL_RUN;
      gcnt_r <= 8'h00;
    end else begin
      case (gst_r)
        `SDM_GL_RUN: begin
          if (run & all_idle & (cmd == `SDM_CMD_REF)) begin
            gst_r <= `SDM_GL_REF; // see [R2] [R6]
            gcnt_r <= REFRESH_CYC;
          end else if (run & all_idle & (cmd == `SDM_CMD_MRS)) begin
            gst_r <= `SDM_GL_MRS; // see [R3] [R6]
            gcnt_r <= MODE_CYC;
          end else if (is_pre & ca10) begin
            gst_r <= `SDM_GL_PALL; // see [R4] [R7]
            gcnt_r <= PRECHARGE_CYC;
          end
        end
        default: begin
          // Commands are ignored until the count runs out
          if (g_done)
            gst_r <= `SDM_GL_RUN; // see [R1]
          gcnt_r <= gcnt_r - 8'h01;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Burst tracker
  // ----------------------------------------
  reg brst_r;
  reg bwr_r;
  reg [1:0] bbank_r;
  reg [7:0] bbeat_r;
  wire beat;
  wire b_end;
  wire b_cut;

  assign beat = is_rw | brst_r;
  // Last beat or terminate ends the newest burst
  assign b_end = brst_r & ~is_rw &
                 ((bbeat_r == BURST_LEN - 1) | is_bst); // see [R8]
  assign b_cut = brst_r & is_rw & (cba != bbank_r);

  // Newest read or write owns the data bus
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      brst_r <= 1'b0;
      bwr_r <= 1'b0;
      bbank_r <= 2'h0;
      bbeat_r <= 8'h00;
    end else if (is_rw) begin
      brst_r <= (BURST_LEN > 1); // see [R19]
      bwr_r <= is_wr;
      bbank_r <= cba;
      bbeat_r <= 8'h01;
    end else if (b_end | (is_pre & (ca10 | (cba == bbank_r)))) begin
      brst_r <= 1'b0;
    end else if (brst_r) begin
      bbeat_r <= bbeat_r + 8'h01;
    end
  end

  // ----------------------------------------
  // Per-bank state machines
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NBANK; gi = gi + 1) begin : g_bank
      reg [3:0] st_r;
      reg [7:0] cnt_r;
      wire me;
      wire mine;
      wire cut;
      wire fin;

      assign me = (cba == gi);
      assign mine = brst_r & (bbank_r == gi);
      assign cut = b_cut & (bbank_r == gi);
      assign fin = b_end & mine;
      assign bk_idle[gi] = (st_r == `SDM_BK_IDLE);
      assign bank_state[4*gi+3:4*gi] = st_r;

      // Bank transitions, commands to other banks pass freely
      always @(posedge sys_clk) begin
        if (!rst_b) begin
          st_r <= `SDM_BK_IDLE;
          cnt_r <= 8'h00;
        end else if (g_done) begin
          st_r <= `SDM_BK_IDLE; // see [R2] [R3] [R4]
        end else if (is_pre & (ca10 | me) & ~bk_idle[gi]) begin
          st_r <= `SDM_BK_PRE; // see [R11] [R14]
          cnt_r <= PRECHARGE_CYC;
        end else if (is_rw & me) begin
          if (ca10)
            st_r <= is_wr ? `SDM_BK_WRAP : `SDM_BK_RDAP;
          else
            st_r <= is_wr ? `SDM_BK_WR : `SDM_BK_RD;
        end else begin
          case (st_r)
            `SDM_BK_IDLE: begin
              if (is_act & me) begin
                st_r <= `SDM_BK_ACTG;
                cnt_r <= ACT_CYC;
              end
            end
            `SDM_BK_ACTG, `SDM_BK_PRE, `SDM_BK_WREC: begin
              if (cnt_r == 8'h01)
                st_r <= (st_r == `SDM_BK_ACTG) ? `SDM_BK_ACTV :
                        (st_r == `SDM_BK_PRE) ? `SDM_BK_IDLE :
                        `SDM_BK_PRE; // see [R5]
              if (cnt_r == 8'h01 && st_r == `SDM_BK_WREC)
                cnt_r <= PRECHARGE_CYC;
              else
                cnt_r <= cnt_r - 8'h01;
            end
            `SDM_BK_RD, `SDM_BK_WR: begin
              if (cut | fin | ~mine)
                st_r <= `SDM_BK_ACTV; // see [R16] [R17] [R18] [R19]
            end
            `SDM_BK_RDAP: begin
              if (cut | fin | ~mine) begin
                st_r <= `SDM_BK_PRE; // see [R15] [R20] [R21]
                cnt_r <= PRECHARGE_CYC;
              end
            end
            `SDM_BK_WRAP: begin
              if (cut | fin | ~mine) begin
                st_r <= `SDM_BK_WREC; // see [R22] [R23]
                cnt_r <= WREC_CYC;
              end
            end
            default: begin
              st_r <= st_r;
            end
          endcase
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Read data pipeline
  // ----------------------------------------
  reg [READ_LATENCY-1:0] rvld_r;
  reg [2*READ_LATENCY-1:0] rbank_r;
  wire rd_beat;
  wire b_end_stop;
  wire [1:0] beat_bank;

  assign beat_bank = is_rw ? cba : bbank_r;
  assign b_end_stop = is_bst | (is_pre & (ca10 | (cba == bbank_r)));
  assign rd_beat = is_rd | (brst_r & ~bwr_r & ~is_wr & ~b_end_stop);
  assign mem_rd_en = rvld_r[READ_LATENCY-1];
  assign mem_rd_bank = rbank_r[2*READ_LATENCY-1:2*READ_LATENCY-2];

  // Beats of the old bank drain first, so switch-over is seamless
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      rvld_r <= {READ_LATENCY{1'b0}};
      rbank_r <= {(2*READ_LATENCY){1'b0}};
    end else if (is_wr) begin
      rvld_r <= {READ_LATENCY{1'b0}}; // see [R17] [R21]
    end else begin
      rvld_r <= {rvld_r[READ_LATENCY-2:0], rd_beat}; // see [R16] [R20]
      rbank_r <= {rbank_r[2*READ_LATENCY-3:0], beat_bank};
    end
  end

  // Output lanes, masked two clocks after the mask pin
  reg [3:0] dqm_d1_r;
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      dq_out <= 32'h00000000;
      dq_oe <= 4'h0;
      dqm_d1_r <= 4'hF;
    end else begin
      dqm_d1_r <= cdqm;
      dq_out <= mem_rd_data;
      dq_oe <= {4{mem_rd_en}} & ~dqm_d1_r; // see [R18] [R22]
    end
  end

  // ----------------------------------------
  // Write data path into the FIFO
  // ----------------------------------------
  wire wr_beat;

  // Data at an interrupting edge belongs to the new burst only
  assign wr_beat = (is_wr | (brst_r & bwr_r & ~is_rd & ~b_end_stop)) &
                   (cdqm != 4'hF); // see [R19] [R23]

  sdm_fifo #(
    .WIDTH(38),
    .DEPTH(FIFO_DEPTH),
    .AW(3)
  ) u_wfifo (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .in_valid(wr_beat),
    .in_ready(wr_fifo_ready),
    .in_data({beat_bank, cdqm, cdq}),
    .out_valid(st_valid),
    .out_ready(st_ready),
    .out_data(st_data)
  );
endmodule // sdm_bank_ctrl
`default_nettype wire

// ==== pkg/sdm_map.vh ====
`ifndef SDM_MAP_VH
`define SDM_MAP_VH
// ----------------------------------------
// Clock and timing figures
// ----------------------------------------
`define SDM_CLK_NS 10
`define SDM_TRP_NS 20
`define SDM_ACTIVATE_TO_ACCESS_DELAY_NS 20
`define SDM_REFRESH_CYCLE_TIME_NS 70
`define SDM_MODE_SET_DELAY_NS 20
`define SDM_TWR_NS 15
`define SDM_SELF_REFRESH_EXIT_DELAY_NS 70
`define SDM_CYC(ns) (((ns) + `SDM_CLK_NS - 1) / `SDM_CLK_NS)
`define SDM_TRP_CYC `SDM_CYC(`SDM_TRP_NS)
`define SDM_ACTIVATE_TO_ACCESS_DELAY_CYC `SDM_CYC(`SDM_ACTIVATE_TO_ACCESS_DELAY_NS)
`define SDM_REFRESH_CYCLE_TIME_CYC `SDM_CYC(`SDM_REFRESH_CYCLE_TIME_NS)
`define SDM_MODE_SET_DELAY_CYC `SDM_CYC(`SDM_MODE_SET_DELAY_NS)
`define SDM_TWR_CYC `SDM_CYC(`SDM_TWR_NS)
`define SDM_SELF_REFRESH_EXIT_DELAY_CYC `SDM_CYC(`SDM_SELF_REFRESH_EXIT_DELAY_NS)
// ----------------------------------------
// Command codes {cs_n, ras_n, cas_n, we_n}
// ----------------------------------------
`define SDM_CMD_MRS 4'h0
`define SDM_CMD_REF 4'h1
`define SDM_CMD_PRE 4'h2
`define SDM_CMD_ACT 4'h3
`define SDM_CMD_WR 4'h4
`define SDM_CMD_RD 4'h5
`define SDM_CMD_BST 4'h6
// ----------------------------------------
// Bank state codes
// ----------------------------------------
`define SDM_BK_IDLE 4'h0
`define SDM_BK_ACTG 4'h1
`define SDM_BK_ACTV 4'h2
`define SDM_BK_RD 4'h3
`define SDM_BK_WR 4'h4
`define SDM_BK_RDAP 4'h5
`define SDM_BK_WRAP 4'h6
`define SDM_BK_WREC 4'h7
`define SDM_BK_PRE 4'h8
// ----------------------------------------
// Global state codes
// ----------------------------------------
`define SDM_GL_RUN 2'h0
`define SDM_GL_REF 2'h1
`define SDM_GL_MRS 2'h2
`define SDM_GL_PALL 2'h3
`endif

// ==== bench/sdm_bank_ctrl_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
// ------
// Bank tracker checks
// ------
module sdm_bank_ctrl_checker #(
  parameter NBANK = 4
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [31:0] dq_out,
  input wire logic mem_rd_en,
  input wire logic [31:0] mem_rd_data,
  input wire logic st_valid,
  input wire logic st_ready,
  input wire logic [37:0] st_data,
  input wire logic [4*NBANK-1:0] bank_state,
  input wire logic [1:0] glob_state,
  input wire logic all_idle
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  // Reset leaves everything idle
  property p_reset;
    @(posedge sys_clk) disable iff (1'b0)
    !rst_b |=> glob_state == 2'h0 && bank_state == '0 && !st_valid;
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset state wrong");
  property p_ref;
    $rose(glob_state == 2'h1) |-> (glob_state == 2'h1) [*5]
      ##[1:4] (glob_state == 2'h0 && all_idle);
  endproperty
  a_ref: assert property (p_ref)
    else $error("refresh period wrong");
  property p_mrs;
    $rose(glob_state == 2'h2) |-> ##[1:4] glob_state == 2'h0 && all_idle;
  endproperty
  a_mrs: assert property (p_mrs)
    else $error("mode period wrong");
  property p_pall;
    $rose(glob_state == 2'h3) |-> ##[1:4] glob_state == 2'h0 && all_idle;
  endproperty
  a_pall: assert property (p_pall)
    else $error("precharge-all period wrong");
  property p_ap;
    $rose(bank_state[3:0] == 4'h8) |-> ##[1:4] bank_state[3:0] == 4'h0;
  endproperty
  a_ap: assert property (p_ap)
    else $error("bank precharge too long");
  // No read traffic while refreshing or loading mode
  property p_quiet;
    glob_state == 2'h1 || glob_state == 2'h2 |-> !mem_rd_en;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("read during global period");
  property p_rdata;
    mem_rd_en |=> dq_out == $past(mem_rd_data);
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("read data not forwarded");
  property p_hold;
    st_valid && !st_ready |=> st_valid && $stable(st_data);
  endproperty
  a_hold: assert property (p_hold)
    else $error("stalled write data lost");
  property p_cap;
    $rose(bank_state[7:4] == 4'h3) && $past(bank_state[3:0]) == 4'h5
      |-> ##[0:2] bank_state[3:0] == 4'h8;
  endproperty
  a_cap: assert property (p_cap)
    else $error("no concurrent precharge");
endmodule // sdm_bank_ctrl_checker

bind sdm_bank_ctrl sdm_bank_ctrl_checker #(.NBANK(NBANK)) u_chk (
  .sys_clk(sys_clk), .rst_b(rst_b), .dq_out(dq_out),
  .mem_rd_en(mem_rd_en), .mem_rd_data(mem_rd_data),
  .st_valid(st_valid), .st_ready(st_ready), .st_data(st_data),
  .bank_state(bank_state), .glob_state(glob_state),
  .all_idle(all_idle));
`default_nettype wire

// ==== bench/sdm_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "sdm_map.vh"
// ------
// Command issuer and read data source
// ------
module sdm_host_model (
  input wire logic sys_clk,
  input wire logic [1:0] mem_rd_bank,
  output logic cke,
  output logic cs_b,
  output logic ras_b,
  output logic cas_b,
  output logic we_b,
  output logic [1:0] bank_addr,
  output logic a10,
  output logic [3:0] byte_mask,
  output logic [31:0] dq_in,
  output logic [31:0] mem_rd_data
);
  logic [7:0] tick_r = 8'h00;
  // Read data moves every cycle so a stale beat shows
  always @(posedge sys_clk) tick_r <= tick_r + 8'h01;
  assign mem_rd_data = {22'h0, mem_rd_bank, tick_r};
  // Pins idle as nop with clock enable high
  initial begin
    cke = 1'b1;
    {cs_b, ras_b, cas_b, we_b} = 4'h7;
    bank_addr = 2'h0;
    a10 = 1'b0;
    byte_mask = 4'h0;
    dq_in = 32'h0;
  end
  // One command, write beats follow; rel low chains the next command
  task automatic cmd(input logic [3:0] c, input logic [1:0] b,
    input logic ap, input logic [31:0] d, input logic rel);
    int i;
    {cs_b, ras_b, cas_b, we_b} = c;
    bank_addr = b;
    a10 = ap;
    dq_in = d;
    @(posedge sys_clk);
    #1;
    if (c == `SDM_CMD_WR) begin
      {cs_b, ras_b, cas_b, we_b} = 4'h7;
      for (i = 1; i < 4; i++) begin
        dq_in = d + i;
        @(posedge sys_clk);
        #1;
      end
    end
    if (rel) begin
      {cs_b, ras_b, cas_b, we_b} = 4'h7;
      dq_in = ~dq_in;
    end
  endtask
endmodule // sdm_host_model
`default_nettype wire

// ==== bench/sdm_bank_ctrl_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "sdm_map.vh"
// ------
// Bank tracker testbench
// ------
module sdm_bank_ctrl_tb;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic st_ready = 1'b0;
  wire cke, cs_b, ras_b, cas_b, we_b, a10, mem_rd_en, st_valid;
  wire wr_fifo_ready, all_idle;
  wire [1:0] bank_addr, mem_rd_bank, glob_state;
  wire [3:0] byte_mask, dq_oe;
  wire [31:0] dq_in, dq_out, mem_rd_data;
  wire [37:0] st_data;
  wire [15:0] bank_state;
  int n_mismatch = 0;
  int cmp_count = 0;
  int beats = 0;
  logic [1:0] first_bank = 2'h3;
  logic [1:0] last_bank = 2'h3;

  sdm_bank_ctrl DUT (.sys_clk(sys_clk), .rst_b(rst_b), .cke(cke),
    .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b),
    .bank_addr(bank_addr), .a10(a10), .byte_mask(byte_mask),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .mem_rd_en(mem_rd_en), .mem_rd_bank(mem_rd_bank),
    .mem_rd_data(mem_rd_data), .st_valid(st_valid),
    .st_ready(st_ready), .st_data(st_data),
    .wr_fifo_ready(wr_fifo_ready), .bank_state(bank_state),
    .glob_state(glob_state), .all_idle(all_idle));
  sdm_host_model host (.sys_clk(sys_clk), .mem_rd_bank(mem_rd_bank),
    .cke(cke), .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b),
    .bank_addr(bank_addr), .a10(a10), .byte_mask(byte_mask),
    .dq_in(dq_in), .mem_rd_data(mem_rd_data));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  // Count driven read beats and note their banks
  always @(posedge sys_clk) begin
    if (dq_oe != 4'h0) begin
      beats <= beats + 1;
      last_bank <= dq_out[9:8];
      if (beats == 0)
        first_bank <= dq_out[9:8];
    end
  end

  task automatic summarize();
    $display("mismatches=%0d compares=%0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [38:0] got, input logic [38:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Field k: bank k, or global state when k is 4
  function automatic logic [3:0] fld(input int k);
    return (k == 4) ? {2'h0, glob_state} : bank_state[4*k +: 4];
  endfunction
  task automatic wait_st(input int k, input logic [3:0] v);
    int i;
    for (i = 0; i < 40; i++) begin
      @(posedge sys_clk);
      #1;
      if (fld(k) === v) return;
    end
    chk(fld(k), v);
    summarize();
  endtask
  task automatic hold_st(input int k, input logic [3:0] v);
    repeat (6) begin
      @(posedge sys_clk);
      #1;
      chk(fld(k), v);
    end
  endtask

  // Precharge elsewhere leaves a full burst
  task automatic s_read();
    host.cmd(`SDM_CMD_ACT, 2'h0, 1'b0, 32'h0, 1'b0);
    host.cmd(`SDM_CMD_ACT, 2'h1, 1'b0, 32'h0, 1'b1);
    wait_st(1, `SDM_BK_ACTV);
    beats = 0;
    host.cmd(`SDM_CMD_RD, 2'h0, 1'b0, 32'h0, 1'b0);
    host.cmd(`SDM_CMD_PRE, 2'h1, 1'b0, 32'h0, 1'b1);
    wait_st(1, `SDM_BK_IDLE);
    repeat (6) @(posedge sys_clk);
    #1;
    chk(beats, 4);
  endtask
  // Read cuts a read with auto precharge
  task automatic s_intr();
    host.cmd(`SDM_CMD_ACT, 2'h1, 1'b0, 32'h0, 1'b1);
    wait_st(1, `SDM_BK_ACTV);
    beats = 0;
    host.cmd(`SDM_CMD_RD, 2'h0, 1'b1, 32'h0, 1'b0);
    host.cmd(`SDM_CMD_RD, 2'h1, 1'b0, 32'h0, 1'b1);
    wait_st(0, `SDM_BK_PRE);
    wait_st(0, `SDM_BK_IDLE);
    repeat (8) @(posedge sys_clk);
    #1;
    chk(beats, 5);
    chk({first_bank, last_bank}, 4'h1);
  endtask
  // Terminate aimed at the bursting bank leaves one beat
  task automatic s_term();
    beats = 0;
    host.cmd(`SDM_CMD_RD, 2'h1, 1'b0, 32'h0, 1'b0);
    host.cmd(`SDM_CMD_BST, 2'h1, 1'b0, 32'h0, 1'b1);
    repeat (8) @(posedge sys_clk);
    #1;
    chk(beats, 1);
  endtask
  // Fill the write buffer while stalled, then drain
  task automatic s_write();
    int i;
    host.cmd(`SDM_CMD_ACT, 2'h2, 1'b0, 32'h0, 1'b1);
    wait_st(2, `SDM_BK_ACTV);
    host.cmd(`SDM_CMD_WR, 2'h2, 1'b0, 32'h100, 1'b0);
    host.cmd(`SDM_CMD_WR, 2'h2, 1'b0, 32'h200, 1'b1);
    repeat (5) @(posedge sys_clk);
    #1;
    chk(wr_fifo_ready, 1'b0);
    st_ready = 1'b1;
    for (i = 0; i < 8; i++) begin
      chk({st_valid, st_data},
          {3'h6, 4'h0, 32'h100 * (i / 4 + 1) + i % 4});
      @(posedge sys_clk);
      #1;
    end
    chk(st_valid, 1'b0);
  endtask
  // Write cuts a read, mask raised the clock before
  task automatic s_rdwr();
    beats = 0;
    st_ready = 1'b0;
    host.byte_mask = 4'hF;
    host.cmd(`SDM_CMD_RD, 2'h1, 1'b0, 32'h0, 1'b0);
    host.byte_mask = 4'h0;
    host.cmd(`SDM_CMD_WR, 2'h2, 1'b0, 32'h300, 1'b1);
    repeat (8) @(posedge sys_clk);
    #1;
    chk(beats, 0);
    chk({st_valid, st_data}, {3'h6, 4'h0, 32'h300});
    st_ready = 1'b1;
    repeat (6) @(posedge sys_clk);
    #1;
    chk(st_valid, 1'b0);
  endtask
  // Refusals and global periods
  task automatic s_global();
    host.cmd(`SDM_CMD_PRE, 2'h0, 1'b0, 32'h0, 1'b1);
    hold_st(0, `SDM_BK_IDLE);
    host.cmd(`SDM_CMD_REF, 2'h0, 1'b0, 32'h0, 1'b1);
    hold_st(4, 4'h0);
    host.cmd(`SDM_CMD_PRE, 2'h0, 1'b1, 32'h0, 1'b1);
    wait_st(4, 4'h3);
    wait_st(4, 4'h0);
    chk(all_idle, 1'b1);
    host.cmd(`SDM_CMD_REF, 2'h0, 1'b0, 32'h0, 1'b1);
    wait_st(4, 4'h1);
    wait_st(4, 4'h0);
    host.cmd(`SDM_CMD_MRS, 2'h0, 1'b0, 32'h0, 1'b1);
    wait_st(4, 4'h2);
    wait_st(4, 4'h0);
  endtask
  // Clock enable low blocks commands
  task automatic s_cke();
    host.cke = 1'b0;
    host.cmd(`SDM_CMD_ACT, 2'h3, 1'b0, 32'h0, 1'b1);
    hold_st(3, `SDM_BK_IDLE);
  endtask

  initial begin
    repeat (8) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    repeat (14) @(posedge sys_clk);
    #1;
    s_read();
    s_intr();
    s_term();
    s_write();
    s_rdwr();
    s_global();
    s_cke();
    summarize();
  end
endmodule // sdm_bank_ctrl_tb
`default_nettype wire
